/* File: core/ldo_level_decode.v */
`timescale 1ns/1ps
`include "ldo_thermal_map.vh"

// ****************************************
// Level code to millivolts
// ****************************************
// KIND 0: six-bit 50 mV scale, KIND 1: five-bit 100 mV scale,
// KIND 2: six-bit scale extended below 1 V
module ldo_level_decode #(
	parameter KIND = 0
) (
	input  wire [5:0]  level,
	output reg  [11:0] millivolts
);

	reg [11:0] fine;
	reg [11:0] coarse;

	always @* begin
		fine   = `MV_BASE + ({6'h00, level - `FINE_KNEE} * `MV_FINE_STEP);
		coarse = `MV_BASE
			+ ({6'h00, level - `COARSE_KNEE} * `MV_COARSE_STEP);
		millivolts = `MV_BASE;
		case (KIND)
		0: begin
			if (level <= `FINE_KNEE)
				millivolts = `MV_BASE;
			else if (fine > `MV_TOP)
				millivolts = `MV_TOP;
			else
				millivolts = fine;
		end
		1: begin
			if (level <= `COARSE_KNEE)
				millivolts = `MV_BASE;
			else if (coarse > `MV_TOP)
				millivolts = `MV_TOP;
			else
				millivolts = coarse;
		end
		default: begin
			if (level <= `COARSE_KNEE)
				millivolts = `MV_EXT_LOW
					+ ({6'h00, level} * `MV_FINE_STEP);
			else if (level <= `FINE_KNEE)
				millivolts = `MV_BASE;
			else if (fine > `MV_TOP)
				millivolts = `MV_TOP;
			else
				millivolts = fine;
		end
		endcase
	end

endmodule // ldo_level_decode

/* File: core/ldo_thermal_map.vh */
`ifndef LDO_THERMAL_MAP_VH
`define LDO_THERMAL_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_LDO_ONE      8'h30
`define OFS_LDO_TWO      8'h31
`define OFS_LDO_FIVE     8'h32
`define OFS_LDO_EIGHT    8'h33
`define OFS_LDO_SEVEN    8'h34
`define OFS_LDO_SIX      8'h35
`define OFS_LDO_FOUR     8'h36
`define OFS_LDO_THREE    8'h37
`define OFS_THERMAL      8'h38

// ****************************************
// Field positions
// ****************************************
`define MODE_MSB         1
`define MODE_LSB         0
`define LEVEL_LSB        2
`define WIDE_LEVEL_MSB   7
`define NARROW_LEVEL_MSB 6
`define HOT_DIE_FLAG_BIT     5
`define OVERTEMP_SHUTDOWN_FLAG_BIT     4
`define THERM_SEL_MSB    3
`define THERM_SEL_LSB    2
`define THERM_EN_BIT     0

// ****************************************
// Reset values and write masks
// ****************************************
`define LDO_CTRL_RST     8'h00
`define THERM_SEL_RST    2'h3
`define THERM_EN_RST     1'h1
`define WIDE_WR_MASK     8'hff
`define NARROW_WR_MASK   8'h7f
`define THERM_WR_MASK    8'h0d

// ****************************************
// Mode codes
// ****************************************
`define MODE_ACTIVE      2'h1
`define MODE_SLEEP       2'h3

// ****************************************
// Voltage scale in millivolts
// ****************************************
`define MV_BASE          12'h3e8
`define MV_FINE_STEP     12'h032
`define MV_COARSE_STEP   12'h064
`define MV_TOP           12'hce4
`define MV_EXT_LOW       12'h320
`define MV_TRACK_MAX     12'h5dc
`define FINE_KNEE        6'h04
`define COARSE_KNEE      6'h02

`endif

/* File: core/ldo_thermal_regs.v */
`timescale 1ns/1ps
`include "ldo_thermal_map.vh"

// Functional notes
// - Mode 01 is on at full power, 11 on at low power, 00 and 10 off; reset 0.
// - Regulators one and two map the six-bit level in 50 mV steps, 5 is 1.05 V.
// - Regulators one and two give 1 V for every level code up to 4.
// - Five-bit regulators give 1 V up to code 2, then 100 mV steps to 3.3 V.
// - Regulator four codes 0, 1 and 2 give 0.8, 0.85 and 0.9 V.
// - Regulator four range is 1-3.3 V untracked and 0.8-1.5 V tracked.
// - With tracking on and core rail one active, regulator four follows it.
// - Bit 5 of the thermal register reads the hot-die detector live.
// - Bit 4 of the thermal register reads the shutdown detector live.
// - Thermal bits 3:2 choose the hot-die threshold and reset to 11.
// - Thermal bits 5:2 reset on general reset, bit 0 on turn-off reset.
// - Thermal bit 0 enables the shutdown module and defaults to one.
// - Every regulator control register returns to default on turn-off reset.
// - Regulator five's register belongs to the turn-off reset domain.
module ldo_thermal_regs (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        turnOffReset,
	input  wire        generalReset,
	input  wire [7:0]  regAddr,
	input  wire [7:0]  regWrData,
	input  wire        regWrEn,
	input  wire        regRdEn,
	output reg  [7:0]  regRdData,
	output reg         regRdValid,
	output wire        regHit,
	input  wire        hotDieDetect,
	input  wire        overtempDetect,
	input  wire        trackEnable,
	input  wire        coreRailOneActive,
	input  wire [11:0] coreRailOneMv,
	output reg  [7:0]  ldoOn,
	output reg  [7:0]  ldoLowPower,
	output reg  [95:0] ldoMillivolts,
	output reg         ldoFourRangeError,
	output reg  [1:0]  hot_die_threshold_choice,
	output reg         shutdownEnable
);

	// ****************************************
	// Register index decode
	// ****************************************
	// Index is the regulator number minus one; bit 3 marks a hit.
	function [3:0] ldoIndex;
		input [7:0] addr;
		begin
			case (addr)
			`OFS_LDO_ONE:   ldoIndex = 4'h8;
			`OFS_LDO_TWO:   ldoIndex = 4'h9;
			`OFS_LDO_THREE: ldoIndex = 4'ha;
			`OFS_LDO_FOUR:  ldoIndex = 4'hb;
			`OFS_LDO_FIVE:  ldoIndex = 4'hc;
			`OFS_LDO_SIX:   ldoIndex = 4'hd;
			`OFS_LDO_SEVEN: ldoIndex = 4'he;
			`OFS_LDO_EIGHT: ldoIndex = 4'hf;
			default:        ldoIndex = 4'h0;
			endcase
		end
	endfunction

	// Regulators one, two and four hold a six-bit level code.
	function wideLevel;
		input [2:0] idx;
		begin
			case (idx)
			3'h0:    wideLevel = 1'b1;
			3'h1:    wideLevel = 1'b1;
			3'h3:    wideLevel = 1'b1;
			default: wideLevel = 1'b0;
			endcase
		end
	endfunction

	// Mode field decode shared by enable and low power outputs.
	function [1:0] modeDecode;
		input [1:0] mode;
		begin
			case (mode)
			`MODE_ACTIVE: modeDecode = 2'h1;
			`MODE_SLEEP:  modeDecode = 2'h3;
			default:      modeDecode = 2'h0;
			endcase
		end
	endfunction

	wire [3:0] wrIdx;
	wire [3:0] rdIdx;
	wire       thermHit;

	assign wrIdx    = ldoIndex(regAddr);
	assign rdIdx    = ldoIndex(regAddr);
	assign thermHit = (regAddr == `OFS_THERMAL);
	assign regHit   = wrIdx[3] | thermHit;

	// ****************************************
	// Detector synchronisers
	// ****************************************
	// Comparator outputs come from the analog side and may glitch.
	wire [1:0] detSync;

	sync_two_flop #(
		.WIDTH(2)
	) u_detSync (
		.ref_clk(ref_clk),
		.rst    (rst),
		.asyncIn({hotDieDetect, overtempDetect}),
		.syncOut(detSync)
	);

	reg hot_die_flag;
	reg overtemp_shutdown_flag;

	always @(posedge ref_clk) begin
		if (rst || generalReset) begin
			hot_die_flag           <= 1'b0;
			overtemp_shutdown_flag <= 1'b0;
		end else begin
			hot_die_flag           <= detSync[1];
			overtemp_shutdown_flag <= detSync[0];
		end
	end

	// ****************************************
	// Regulator control registers
	// ****************************************
	wire [63:0] ctrlFlat;
	wire [95:0] decodedMv;

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : gLdo
			localparam IS_WIDE = (g == 0) || (g == 1) || (g == 3);
			localparam KIND    = (g == 3) ? 2 : (IS_WIDE ? 0 : 1);
			localparam [7:0] MASK = IS_WIDE ? `WIDE_WR_MASK
				: `NARROW_WR_MASK;

			reg  [7:0]  ctrl;
			wire [5:0]  level;
			wire [11:0] mv;

			// Turn-off reset covers every regulator, five included.
			always @(posedge ref_clk) begin
				if (rst || turnOffReset)
					ctrl <= `LDO_CTRL_RST;
				else if (regWrEn && wrIdx[3] && (wrIdx[2:0] == g))
					ctrl <= regWrData & MASK;
			end

			assign level = IS_WIDE
				? ctrl[`WIDE_LEVEL_MSB:`LEVEL_LSB]
				: {1'b0, ctrl[`NARROW_LEVEL_MSB:`LEVEL_LSB]};
			assign ctrlFlat[g*8 +: 8] = ctrl;

			ldo_level_decode #(
				.KIND(KIND)
			) u_decode (
				.level     (level),
				.millivolts(mv)
			);

			assign decodedMv[g*12 +: 12] = mv;
		end
	endgenerate

	// ****************************************
	// Thermal register
	// ****************************************
	always @(posedge ref_clk) begin
		if (rst || generalReset)
			hot_die_threshold_choice <= `THERM_SEL_RST;
		else if (regWrEn && thermHit)
			hot_die_threshold_choice <=
				regWrData[`THERM_SEL_MSB:`THERM_SEL_LSB];
	end

	// Shutdown enable sits in the turn-off domain, not the general one.
	always @(posedge ref_clk) begin
		if (rst || turnOffReset)
			shutdownEnable <= `THERM_EN_RST;
		else if (regWrEn && thermHit)
			shutdownEnable <= regWrData[`THERM_EN_BIT];
	end

	wire [7:0] thermImage;

	assign thermImage = {2'h0, hot_die_flag, overtemp_shutdown_flag,
		hot_die_threshold_choice, 1'b0, shutdownEnable} & 8'h3d;

	// ****************************************
	// Read port
	// ****************************************
	// Unmapped addresses read zero so a stray poll never sees stale data.
	reg [7:0] next_regRdData;

	always @* begin
		next_regRdData = 8'h00;
		if (rdIdx[3])
			next_regRdData = ctrlFlat[rdIdx[2:0]*8 +: 8]
				& (wideLevel(rdIdx[2:0]) ? `WIDE_WR_MASK
				: `NARROW_WR_MASK);
		else if (thermHit)
			next_regRdData = thermImage;
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			regRdData  <= 8'h00;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRdEn;
			if (regRdEn)
				regRdData <= next_regRdData;
		end
	end

	// ****************************************
	// Supply state outputs
	// ****************************************
	reg [7:0] next_ldoOn;
	reg [7:0] next_ldoLowPower;
	reg [1:0] modeBits;
	integer   i;

	always @* begin
		next_ldoOn       = 8'h00;
		next_ldoLowPower = 8'h00;
		modeBits         = 2'h0;
		for (i = 0; i < 8; i = i + 1) begin
			modeBits = modeDecode(ctrlFlat[i*8 +: 2]);
			next_ldoOn[i]       = modeBits[0];
			next_ldoLowPower[i] = modeBits[1];
		end
	end

	// ****************************************
	// Output voltages and tracking
	// ****************************************
	// Tracking only takes over while core rail one is actually active.
	wire        tracking;
	wire [11:0] fourMv;

	assign tracking = trackEnable && coreRailOneActive;
	assign fourMv   = tracking ? coreRailOneMv
		: decodedMv[3*12 +: 12];

	reg [95:0] next_ldoMillivolts;
	reg        next_rangeError;

	always @* begin
		next_ldoMillivolts          = decodedMv;
		next_ldoMillivolts[36 +: 12] = fourMv;
		next_rangeError = 1'b0;
		if (trackEnable)
			next_rangeError = (decodedMv[36 +: 12] > `MV_TRACK_MAX);
		else
			next_rangeError = (decodedMv[36 +: 12] < `MV_BASE);
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			ldoOn             <= 8'h00;
			ldoLowPower       <= 8'h00;
			ldoMillivolts     <= 96'h0;
			ldoFourRangeError <= 1'b0;
		end else begin
			ldoOn             <= next_ldoOn;
			ldoLowPower       <= next_ldoLowPower;
			ldoMillivolts     <= next_ldoMillivolts;
			ldoFourRangeError <= next_rangeError;
		end
	end

endmodule // ldo_thermal_regs

/* File: core/sync_two_flop.v */
`timescale 1ns/1ps
`include "ldo_thermal_map.vh"

// ****************************************
// Two-stage level synchroniser
// ****************************************
module sync_two_flop #(
	parameter WIDTH = 2
) (
	input  wire             ref_clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] asyncIn,
	output reg  [WIDTH-1:0] syncOut
);

	reg [WIDTH-1:0] stageOne;

	always @(posedge ref_clk) begin
		if (rst) begin
			stageOne <= {WIDTH{1'b0}};
			syncOut  <= {WIDTH{1'b0}};
		end else begin
			stageOne <= asyncIn;
			syncOut  <= stageOne;
		end
	end

endmodule // sync_two_flop

/* File: tb/ctrl_host.sv */
`timescale 1ns/1ps

// ********************
// Register port host
// ********************
module ctrl_host (
	input  wire       ref_clk,
	input  wire       regRdValid,
	input  wire [7:0] regRdData,
	output reg  [7:0] regAddr,
	output reg  [7:0] regWrData,
	output reg        regWrEn,
	output reg        regRdEn
);
	initial begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
	end

	// Released lines flip so stale data never looks valid
	task wr(input [7:0] a, input [7:0] d);
		@(negedge ref_clk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge ref_clk);
		regWrEn = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask

	task rd(input [7:0] a, output [7:0] q, output v);
		@(negedge ref_clk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge ref_clk);
		regRdEn = 1'b0;
		regAddr = ~a;
		v = regRdValid;
		q = regRdData;
	endtask
endmodule // ctrl_host

/* File: tb/ldo_thermal_regs_sva.sv */
`timescale 1ns/1ps
`include "ldo_thermal_map.vh"

// ********************
// Port checker
// ********************
module ldo_thermal_regs_sva (
	input wire        ref_clk,
	input wire        rst,
	input wire        turnOffReset,
	input wire        generalReset,
	input wire [7:0]  regAddr,
	input wire [7:0]  regWrData,
	input wire        regWrEn,
	input wire        regRdEn,
	input wire [7:0]  regRdData,
	input wire        regRdValid,
	input wire        regHit,
	input wire        trackEnable,
	input wire        coreRailOneActive,
	input wire [11:0] coreRailOneMv,
	input wire [7:0]  ldoOn,
	input wire [7:0]  ldoLowPower,
	input wire [95:0] ldoMillivolts,
	input wire [1:0]  hot_die_threshold_choice,
	input wire        shutdownEnable
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	function automatic [11:0] mvw(input [7:0] d);
		if (d[7:2] <= `FINE_KNEE)
			mvw = `MV_BASE;
		else if (d[7:2] > 6'h32)
			mvw = `MV_TOP;
		else
			mvw = `MV_BASE + 12'(d[7:2] - `FINE_KNEE) * `MV_FINE_STEP;
	endfunction

	function automatic [11:0] mve(input [7:0] d);
		if (d[7:2] < 6'h03)
			mve = `MV_EXT_LOW + 12'(d[7:2]) * `MV_FINE_STEP;
		else
			mve = mvw(d);
	endfunction

	AST_MODE_SLEEP: assert property (regWrEn && regAddr == 8'h30
		&& !turnOffReset && regWrData[1:0] == 2'h3
		|-> ##2 ldoOn[0] && ldoLowPower[0])
		else $error("sleep mode not applied");
	AST_LEVEL_ONE: assert property (regWrEn && regAddr == 8'h30
		&& !turnOffReset
		|-> ##2 ldoMillivolts[11:0] == mvw($past(regWrData, 2)))
		else $error("regulator one level wrong");
	AST_LEVEL_FOUR: assert property (regWrEn && regAddr == 8'h36
		&& !turnOffReset ##1 !(trackEnable && coreRailOneActive)
		|=> ldoMillivolts[47:36] == mve($past(regWrData, 2)))
		else $error("regulator four level wrong");
	AST_HIT: assert property (regHit == (regAddr >= 8'h30
		&& regAddr <= 8'h38))
		else $error("register hit decode wrong");
	AST_TRACK: assert property (trackEnable && coreRailOneActive
		|=> ldoMillivolts[47:36] == $past(coreRailOneMv))
		else $error("regulator four not tracking");
	AST_OFF_RESET: assert property (turnOffReset |-> ##2 ldoOn == 8'h00)
		else $error("regulator left on after turn-off reset");
	AST_SHUT_ON: assert property (turnOffReset |=> shutdownEnable)
		else $error("shutdown module not enabled");
	AST_CHOICE: assert property (regWrEn && regAddr == 8'h38
		&& !generalReset && regWrData[3:2] == 2'h0
		|=> hot_die_threshold_choice == 2'h0)
		else $error("threshold choice not written");
	AST_UNMAPPED: assert property (regRdEn && !regHit
		|=> regRdValid && regRdData == 8'h00)
		else $error("unmapped read not zero");
endmodule // ldo_thermal_regs_sva

bind ldo_thermal_regs ldo_thermal_regs_sva i_ldo_thermal_regs_sva (
	.ref_clk, .rst, .turnOffReset, .generalReset, .regAddr, .regWrData,
	.regWrEn, .regRdEn, .regRdData, .regRdValid, .regHit, .trackEnable,
	.coreRailOneActive, .coreRailOneMv, .ldoOn, .ldoLowPower,
	.ldoMillivolts, .hot_die_threshold_choice, .shutdownEnable
);

/* File: tb/ldo_thermal_regs_test.sv */
`timescale 1ns/1ps

module ldo_thermal_regs_test;
	localparam [39:0] NA = 40'h3735343332;
	localparam [19:0] NI = 20'h25674;
	reg         ref_clk = 1'b0;
	reg         rst = 1'b1;
	reg         turnOffReset = 1'b0;
	reg         generalReset = 1'b0;
	reg         hotDieDetect = 1'b0;
	reg         overtempDetect = 1'b0;
	reg         trackEnable = 1'b0;
	reg         coreRailOneActive = 1'b0;
	reg  [11:0] coreRailOneMv = 12'h000;
	wire [7:0]  regAddr, regWrData, regRdData, ldoOn, ldoLowPower;
	wire        regWrEn, regRdEn, regRdValid, regHit, ldoFourRangeError;
	wire [95:0] ldoMillivolts;
	wire [1:0]  hot_die_threshold_choice;
	wire        shutdownEnable;
	integer     fail_count = 0;
	integer     check_count = 0;
	integer     i;

	always #5 ref_clk = ~ref_clk;

	ldo_thermal_regs i_ldo_thermal_regs (.ref_clk, .rst, .turnOffReset,
		.generalReset, .regAddr, .regWrData, .regWrEn, .regRdEn,
		.regRdData, .regRdValid, .regHit, .hotDieDetect, .overtempDetect,
		.trackEnable, .coreRailOneActive, .coreRailOneMv, .ldoOn,
		.ldoLowPower, .ldoMillivolts, .ldoFourRangeError,
		.hot_die_threshold_choice, .shutdownEnable);
	ctrl_host i_ctrl_host (.ref_clk, .regRdValid, .regRdData, .regAddr,
		.regWrData, .regWrEn, .regRdEn);

	task test_done;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input string n, input [11:0] e, input [11:0] g);
		check_count = check_count + 1;
		if (g !== e) begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	// Valid flag rides above the data byte
	task rdc(input [7:0] a, input [7:0] e, input string n);
		reg [7:0] q;
		reg       v;
		i_ctrl_host.rd(a, q, v);
		chk(n, {4'h1, e}, {3'h0, v, q});
	endtask

	task s2;
		repeat (2) @(negedge ref_clk);
	endtask

	initial begin
		repeat (5000) @(posedge ref_clk);
		fail_count = fail_count + 1;
		test_done;
	end

	initial begin
		repeat (8) @(negedge ref_clk);
		rst = 1'b0;
		for (i = 0; i < 9; i = i + 1)
			rdc(8'(8'h30 + i), (i == 8) ? 8'h0d : 8'h00, "reset");
		rdc(8'h29, 8'h00, "unmapped low");
		rdc(8'h39, 8'h00, "unmapped high");
		for (i = 0; i < 4; i = i + 1) begin
			i_ctrl_host.wr(8'h30, {6'h05, i[1:0]});
			s2;
			chk("mode on", 12'(i[0]), 12'(ldoOn[0]));
			chk("mode low", 12'(i == 3), 12'(ldoLowPower[0]));
			chk("level one", 12'h41a, ldoMillivolts[11:0]);
		end
		for (i = 3; i < 6; i = i + 1) begin
			i_ctrl_host.wr(8'h31, {i[5:0], 2'h1});
			s2;
			chk("level two", (i < 5) ? 12'h3e8 : 12'h41a,
				ldoMillivolts[23:12]);
		end
		i_ctrl_host.wr(8'h31, 8'hc9);
		s2;
		chk("top two", 12'hce4, ldoMillivolts[23:12]);
		for (i = 0; i < 5; i = i + 1) begin
			i_ctrl_host.wr(NA[i*8 +: 8], 8'h8d);
			s2;
			rdc(NA[i*8 +: 8], 8'h0d, "narrow");
			chk("narrow mv", 12'h44c,
				ldoMillivolts[NI[i*4 +: 4]*12 +: 12]);
		end
		i_ctrl_host.wr(8'h37, 8'h65);
		s2;
		chk("narrow top", 12'hce4, ldoMillivolts[35:24]);
		for (i = 0; i < 3; i = i + 1) begin
			i_ctrl_host.wr(8'h36, {i[5:0], 2'h1});
			s2;
			chk("level four", 12'h320 + 12'(i * 50),
				ldoMillivolts[47:36]);
		end
		trackEnable = 1'b1;
		i_ctrl_host.wr(8'h36, 8'hc9);
		s2;
		chk("range tracked", 12'h001, 12'(ldoFourRangeError));
		coreRailOneActive = 1'b1;
		coreRailOneMv = 12'h4b0;
		s2;
		chk("track", 12'h4b0, ldoMillivolts[47:36]);
		trackEnable = 1'b0;
		coreRailOneActive = 1'b0;
		i_ctrl_host.wr(8'h36, 8'h01);
		s2;
		chk("range low", 12'h001, 12'(ldoFourRangeError));
		i_ctrl_host.wr(8'h36, 8'h15);
		s2;
		chk("range ok", 12'h000, 12'(ldoFourRangeError));
		i_ctrl_host.wr(8'h38, 8'hf2);
		rdc(8'h38, 8'h00, "thermal");
		chk("shutdown en", 12'h000, 12'(shutdownEnable));
		chk("threshold", 12'h000, 12'(hot_die_threshold_choice));
		hotDieDetect = 1'b1;
		repeat (4) @(negedge ref_clk);
		rdc(8'h38, 8'h20, "hot die");
		overtempDetect = 1'b1;
		repeat (4) @(negedge ref_clk);
		rdc(8'h38, 8'h30, "overtemp");
		hotDieDetect = 1'b0;
		overtempDetect = 1'b0;
		repeat (4) @(negedge ref_clk);
		generalReset = 1'b1;
		@(negedge ref_clk);
		generalReset = 1'b0;
		rdc(8'h38, 8'h0c, "general reset");
		chk("threshold rst", 12'h003, 12'(hot_die_threshold_choice));
		rdc(8'h30, 8'h17, "kept one");
		turnOffReset = 1'b1;
		@(negedge ref_clk);
		turnOffReset = 1'b0;
		rdc(8'h38, 8'h0d, "turn-off thermal");
		rdc(8'h32, 8'h00, "turn-off five");
		rdc(8'h30, 8'h00, "turn-off one");
		chk("all off", 12'h000, 12'(ldoOn));
		test_done;
	end
endmodule // ldo_thermal_regs_test
